/* gim_defs.vh */
// register offsets, field positions, reset values and interrupt numbers
`ifndef GIM_DEFS_VH
`define GIM_DEFS_VH

`define GIM_OFF_DIR        12'h000
`define GIM_OFF_OUT        12'h004
`define GIM_OFF_IN         12'h008
`define GIM_OFF_INT_STAT   12'h00C
`define GIM_OFF_INT_MASK   12'h010
`define GIM_OFF_IRQ_LINES  12'h014
`define GIM_OFF_INT_SRC    12'h018

`define GIM_PIN_W          16
`define GIM_IRQ_W          32

`define GIM_DIR_RST        16'h4008
`define GIM_OUT_RST        16'hFFFF
`define GIM_MASK_RST       32'h0000_0000
`define GIM_LINES_RST      32'h3E68_00C0

`define GIM_PIN_LED        3
`define GIM_PIN_SCL        6
`define GIM_PIN_SDA        7
`define GIM_PIN_CARD_A     8
`define GIM_PIN_CARD_B     9
`define GIM_PIN_STORAGE    12
`define GIM_PIN_PCI_RST    13
`define GIM_PIN_WDOG       14

`define GIM_IRQ_TIMER0     5
`define GIM_IRQ_TIMER1     11
`define GIM_IRQ_WDOG       16
`define GIM_IRQ_SCL        23
`define GIM_IRQ_SDA        24
`define GIM_IRQ_CARD_A     25
`define GIM_IRQ_CARD_B     26

`endif

/* gim_pin_sync.v */
// two-stage synchroniser for the sixteen port pins
`timescale 1ns/1ns
module gim_pin_sync (
   clk,
   rst_n,
   pin_async,
   pin_sync
);
   input  wire        clk;
   input  wire        rst_n;
   input  wire [15:0] pin_async;
   output reg  [15:0] pin_sync;

   reg [15:0] meta_reg;

   // first stage feeds only the second
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 16'hFFFF;
         pin_sync <= 16'hFFFF;
      end else begin
         meta_reg <= pin_async;
         pin_sync <= meta_reg;
      end
   end
endmodule // gim_pin_sync

/* gim_irq_map.v */
// routes internal and pin sources onto the 32 interrupt lines
`timescale 1ns/1ns
`include "gim_defs.vh"
module gim_irq_map (
   pin_lvl,
   internal_irq,
   irq_lines
);
   input  wire [15:0] pin_lvl;
   input  wire [31:0] internal_irq;
   output reg  [31:0] irq_lines;

   // pin lines overwrite internal slots; i2c lines stay dead
   always @* begin
      irq_lines = internal_irq;
      irq_lines[6]  = pin_lvl[0];
      irq_lines[7]  = pin_lvl[1];
      irq_lines[19] = pin_lvl[2];
      irq_lines[20] = pin_lvl[3];
      irq_lines[21] = pin_lvl[4];
      irq_lines[22] = pin_lvl[5];
      irq_lines[`GIM_IRQ_SCL] = 1'b0;
      irq_lines[`GIM_IRQ_SDA] = 1'b0;
      irq_lines[`GIM_IRQ_CARD_A] = pin_lvl[`GIM_PIN_CARD_A];
      irq_lines[`GIM_IRQ_CARD_B] = pin_lvl[`GIM_PIN_CARD_B];
      irq_lines[27] = pin_lvl[10];
      irq_lines[28] = pin_lvl[11];
      irq_lines[29] = pin_lvl[`GIM_PIN_STORAGE];
   end
endmodule // gim_irq_map

/* gim_gpio.v */
// gpio port with apb registers and interrupt line mapping
//
// Contract
// - thirty-two interrupt lines are fed by internal blocks or eleven pins.
// - timer zero sits on line 5, timer one on line 11, watchdog on line 16.
// - pin 8 feeds line 25 and pin 9 feeds line 26, each shared by two cards.
// - lines 23 and 24 stay unused because pins 6 and 7 carry the i2c bus.
// - three 16-bit registers control the port: direction, output, input.
// - a direction bit of one drives its pin, zero leaves it an input.
// - the output register sets the level on every pin set to output.
// - the input register returns sampled levels of the input pins.
// - pins 0 to 4 reach the user header and may be inputs or outputs.
// - pin 3 as output lights the status indicator when low, off when high.
// - pin 13 is the pci reset input, low meaning reset is asserted.
// - pin 14 is kept for the external watchdog strobe.
// - pin 12 carries the storage card interrupt as an interrupt source.
`timescale 1ns/1ns
`include "gim_defs.vh"
module gim_gpio (
   clk,
   rst_n,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   pin_in,
   pin_out,
   pin_oe,
   timer0_irq,
   timer1_irq,
   wdog_irq,
   other_irq,
   irq_lines,
   pci_reset_n,
   led_on,
   irq
);
   input  wire        clk;
   input  wire        rst_n;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [11:0] paddr;
   input  wire [31:0] pwdata;
   output reg  [31:0] prdata;
   output reg         pready;
   output reg         pslverr;
   input  wire [15:0] pin_in;
   output reg  [15:0] pin_out;
   output reg  [15:0] pin_oe;
   input  wire        timer0_irq;
   input  wire        timer1_irq;
   input  wire        wdog_irq;
   input  wire [31:0] other_irq;
   output reg  [31:0] irq_lines;
   output reg         pci_reset_n;
   output reg         led_on;
   output reg         irq;

   // software-visible registers
   reg  [15:0] pin_direction_reg;
   reg  [15:0] pin_output_data_reg;
   reg  [15:0] pin_input_levels_reg;
   reg  [31:0] int_stat_reg;
   reg  [31:0] int_mask_reg;

   // line history and synced internal sources
   reg  [31:0] lines_prev_reg;
   reg  [31:0] int_src_sync1_reg;
   reg  [31:0] int_src_reg;

   // next values, decode and mapped levels
   reg  [31:0] internal_irq;
   reg  [31:0] rdata_next;
   reg         hit_next;
   wire [15:0] pin_sync;
   wire [15:0] pin_lvl;
   wire [31:0] lines_next;
   wire [31:0] rise;
   wire        wr_en;
   wire        acc_en;
   wire        wr_dir;
   wire        wr_out;
   wire        wr_stat;
   wire        wr_mask;
   wire [31:0] int_stat_next;
   reg  [31:0] prdata_next;
   reg         pready_next;
   reg         pslverr_next;
   reg  [15:0] pin_out_next;
   reg  [15:0] pin_oe_next;
   reg         led_next;
   reg         pci_reset_next;
   reg         irq_next;
   genvar      gi;

   // loop bounds follow the shared header widths
   localparam pin_w = `GIM_PIN_W;
   localparam irq_w = `GIM_IRQ_W;

   gim_pin_sync u_sync (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_async (pin_in),
      .pin_sync  (pin_sync)
   );

   // input pins report their pad level; output pins read as zero
   generate
      for (gi = 0; gi < pin_w; gi = gi + 1) begin : g_pin
         wire driven;
         assign driven      = pin_direction_reg[gi];
         assign pin_lvl[gi] = pin_sync[gi] & ~driven;
      end
   endgenerate

   // internal sources double-synced: they may come from other clocks
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_src_sync1_reg <= 32'h0000_0000;
         int_src_reg       <= 32'h0000_0000;
      end else begin
         int_src_sync1_reg <= internal_irq;
         int_src_reg       <= int_src_sync1_reg;
      end
   end

   // fixed internal slots; pin slots are taken over in the map
   always @* begin
      internal_irq = other_irq;
      internal_irq[`GIM_IRQ_TIMER0] = timer0_irq;
      internal_irq[`GIM_IRQ_TIMER1] = timer1_irq;
      internal_irq[`GIM_IRQ_WDOG]   = wdog_irq;
   end

   gim_irq_map u_map (
      .pin_lvl      (pin_lvl),
      .internal_irq (int_src_reg),
      .irq_lines    (lines_next)
   );

   assign acc_en = psel & penable;
   assign wr_en  = acc_en & pwrite;
   assign rise   = lines_next & ~lines_prev_reg;

   // writes land only at the access edge qualified by pready
   assign wr_dir  = wr_en & pready & (paddr == `GIM_OFF_DIR);
   assign wr_out  = wr_en & pready & (paddr == `GIM_OFF_OUT);
   assign wr_stat = wr_en & pready & (paddr == `GIM_OFF_INT_STAT);
   assign wr_mask = wr_en & pready & (paddr == `GIM_OFF_INT_MASK);

   // one sticky flag per line; a new event beats a write-one clear
   generate
      for (gi = 0; gi < irq_w; gi = gi + 1) begin : g_stat
         wire set_bit;
         wire clr_bit;
         assign set_bit = rise[gi];
         assign clr_bit = wr_stat & pwdata[gi];
         assign int_stat_next[gi] = set_bit | (int_stat_reg[gi] & ~clr_bit);
      end
   endgenerate

   // read mux and address decode
   always @* begin
      rdata_next = 32'h0000_0000;
      hit_next   = 1'b1;
      case (paddr)
         `GIM_OFF_DIR: begin
            rdata_next = {16'h0000, pin_direction_reg};
         end
         `GIM_OFF_OUT: begin
            rdata_next = {16'h0000, pin_output_data_reg};
         end
         `GIM_OFF_IN: begin
            rdata_next = {16'h0000, pin_input_levels_reg};
         end
         `GIM_OFF_INT_STAT: begin
            rdata_next = int_stat_reg;
         end
         `GIM_OFF_INT_MASK: begin
            rdata_next = int_mask_reg;
         end
         `GIM_OFF_IRQ_LINES: begin
            rdata_next = lines_prev_reg;
         end
         `GIM_OFF_INT_SRC: begin
            rdata_next = int_src_reg;
         end
         default: begin
            hit_next = 1'b0;
         end
      endcase
   end

   // answer decided in setup, so it stands through the access cycle
   always @* begin
      pready_next  = psel & ~penable;
      pslverr_next = psel & ~penable & ~hit_next;
      prdata_next  = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         prdata_next = rdata_next;   // bus stays zero outside reads
      end
   end

   // apb slave answers in the first access cycle, no wait states
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         prdata  <= prdata_next;
      end
   end

   // sampled pad levels, refreshed every cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_input_levels_reg <= 16'h0000;
      end else begin
         pin_input_levels_reg <= pin_lvl;
      end
   end

   // port registers; writes land at the access edge with pready high
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_direction_reg    <= `GIM_DIR_RST;
         pin_output_data_reg  <= `GIM_OUT_RST;
      end else begin
         if (wr_dir) begin
            pin_direction_reg <= pwdata[15:0];
         end
         if (wr_out) begin
            pin_output_data_reg <= pwdata[15:0];
         end
      end
   end

   // sticky status on rising line; new event beats a write-one clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_stat_reg   <= 32'h0000_0000;
         // idle image of the lines, so release brings no false event
         lines_prev_reg <= `GIM_LINES_RST;
      end else begin
         lines_prev_reg <= lines_next;
         int_stat_reg   <= int_stat_next;
      end
   end

   // interrupt enables, cleared at reset so nothing fires early
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_mask_reg <= `GIM_MASK_RST;
      end else if (wr_mask) begin
         int_mask_reg <= pwdata;
      end
   end

   // next values of the board-facing flops
   always @* begin
      pin_out_next   = pin_output_data_reg;
      pin_oe_next    = pin_direction_reg;
      // low on pin 13 holds pci reset active
      pci_reset_next = pin_sync[`GIM_PIN_PCI_RST];
      // active-low indicator, only when pin 3 is driven
      led_next       = pin_direction_reg[`GIM_PIN_LED] &
                       ~pin_output_data_reg[`GIM_PIN_LED];
      irq_next       = |(int_stat_reg & int_mask_reg);
   end

   // pin drivers straight from flops, so pads never glitch
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= `GIM_OUT_RST;
         pin_oe  <= 16'h0000;
      end else begin
         pin_out <= pin_out_next;
         pin_oe  <= pin_oe_next;
      end
   end

   // mapped lines and board signals, all registered
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_lines   <= 32'h0000_0000;
         pci_reset_n <= 1'b0;
         led_on      <= 1'b0;
         irq         <= 1'b0;
      end else begin
         irq_lines   <= lines_next;
         pci_reset_n <= pci_reset_next;
         led_on      <= led_next;
         irq         <= irq_next;
      end
   end
endmodule // gim_gpio

/* gim_gpio_monitor.sv */
// checker for the gpio port and interrupt map ports
`timescale 1ns/1ns
module gim_monitor (
   input logic        clk,
   input logic        rst_n,
   input logic        psel,
   input logic        penable,
   input logic        pready,
   input logic        pslverr,
   input logic [15:0] pin_in,
   input logic [15:0] pin_out,
   input logic [15:0] pin_oe,
   input logic        timer0_irq,
   input logic        timer1_irq,
   input logic        wdog_irq,
   input logic [31:0] irq_lines,
   input logic        pci_reset_n,
   input logic        led_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // inputs held long enough to pass both sync stages
   sequence s_setup; psel && !penable; endsequence
   sequence s_tmr; (timer0_irq && timer1_irq && wdog_irq) [*5]; endsequence
   sequence s_pci; (!pin_in[13]) [*5]; endsequence
   property p_apb; s_setup |=> pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_i2c; irq_lines[24:23] == 2'h0; endproperty
   property p_tmr; s_tmr |-> irq_lines[5] && irq_lines[11] && irq_lines[16];
   endproperty
   property p_card; (pin_in[9:8] == 2'h3 && pin_oe[9:8] == 2'h0) [*5]
      |-> irq_lines[26:25] == 2'h3;
   endproperty
   property p_stor; (pin_in[12] && !pin_oe[12]) [*5] |-> irq_lines[29];
   endproperty
   property p_led; led_on == (pin_oe[3] && !pin_out[3]); endproperty
   property p_pci; s_pci |-> !pci_reset_n; endproperty
   a_apb: assert property (p_apb) else $error("no answer");
   a_err: assert property (p_err) else $error("stray error");
   a_i2c: assert property (p_i2c) else $error("bus lines set");
   a_tmr: assert property (p_tmr) else $error("timer line");
   a_card: assert property (p_card) else $error("card line");
   a_stor: assert property (p_stor) else $error("storage line");
   a_led: assert property (p_led) else $error("indicator");
   a_pci: assert property (p_pci) else $error("pci reset");
endmodule // gim_monitor

bind gim_gpio gim_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .timer0_irq(timer0_irq),
   .timer1_irq(timer1_irq), .wdog_irq(wdog_irq), .irq_lines(irq_lines),
   .pci_reset_n(pci_reset_n), .led_on(led_on));

/* gim_board_model.sv */
// board side of the port pins
`timescale 1ns/1ns
module gim_board_model (
   input  logic [15:0] pin_out,
   input  logic [15:0] pin_oe,
   input  logic [15:0] ext_lvl,
   output logic [15:0] pin_lvl
);
   // a driven pin shows the block's level, any other the board's
   assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // gim_board_model

/* tb_gpio_interrupt_mapping.sv */
// self-checking bench for the gpio port and interrupt map
`timescale 1ns/1ns
`include "gim_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module tb_gpio_interrupt_mapping;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, other_irq = 32'h0, prdata, irq_lines, q;
   logic        pready, pslverr, err, pci_reset_n, led_on, irq;
   logic [15:0] pin_in, pin_out, pin_oe, ext_lvl = 16'h0;
   logic        timer0_irq = 0, timer1_irq = 0, wdog_irq = 0;
   int          failures = 0, n_compared = 0;

   always #2 clk = ~clk;

   gim_gpio u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .timer0_irq(timer0_irq),
      .timer1_irq(timer1_irq), .wdog_irq(wdog_irq), .other_irq(other_irq),
      .irq_lines(irq_lines), .pci_reset_n(pci_reset_n), .led_on(led_on),
      .irq(irq));
   gim_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_lvl(ext_lvl), .pin_lvl(pin_in));

   task complete_run;
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one apb transfer, request held until pready is seen
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         failures++;
         complete_run;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(0, `GIM_OFF_DIR, 32'h0);
      `CHK(q, 32'h4008)
      apb(0, `GIM_OFF_OUT, 32'h0);
      `CHK(q, 32'hFFFF)
      `CHK(led_on, 1'b0)
      apb(0, `GIM_OFF_INT_STAT, 32'h0);
      `CHK(q, 32'h0)
      // fixed internal lines beat the other sources
      other_irq <= 32'hFFFF_FFFF;
      repeat (5) @(posedge clk);
      `CHK(irq_lines & 32'h0181_0820, 32'h0)
      timer0_irq <= 1'b1;
      timer1_irq <= 1'b1;
      wdog_irq <= 1'b1;
      repeat (5) @(posedge clk);
      apb(0, `GIM_OFF_IRQ_LINES, 32'h0);
      `CHK(q & 32'h0181_0820, 32'h0001_0820)
      // header pins driven, pin 3 low lights the indicator
      apb(1, `GIM_OFF_DIR, 32'h401F);
      apb(1, `GIM_OFF_OUT, 32'h0015);
      repeat (2) @(posedge clk);
      `CHK(pin_oe, 16'h401F)
      `CHK(pin_out & 16'h401F, 16'h0015)
      `CHK(led_on, 1'b1)
      ext_lvl <= 16'h1300;
      repeat (6) @(posedge clk);
      apb(0, `GIM_OFF_IN, 32'h0);
      `CHK(q, 32'h1300)
      `CHK(pci_reset_n, 1'b0)
      `CHK(irq_lines[29:25], 5'h13)
      ext_lvl <= 16'h2000;
      repeat (6) @(posedge clk);
      `CHK(pci_reset_n, 1'b1)
      // storage pin rises with only its line unmasked
      apb(1, `GIM_OFF_INT_STAT, 32'hFFFF_FFFF);
      apb(1, `GIM_OFF_INT_MASK, 32'h2000_0000);
      ext_lvl <= 16'h3000;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(0, `GIM_OFF_INT_STAT, 32'h0);
      `CHK(q, 32'h2000_0000)
      apb(1, `GIM_OFF_INT_STAT, 32'h2000_0000);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      // masked card line latches status, irq stays low
      ext_lvl <= 16'h3100;
      repeat (6) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(0, `GIM_OFF_INT_STAT, 32'h0);
      `CHK(q, 32'h0200_0000)
      apb(0, 12'h020, 32'h0);
      `CHK(err, 1'b1)
      `CHK(q, 32'h0)
      complete_run;
   end
endmodule // tb_gpio_interrupt_mapping
